// ===== design/fcpa_pkg.sv
// constants and types shared by the flash command and protection host controller
// What this block does
// - high-voltage identification: raise identify pin, hold bit 6 low, bits 1:0 pick item (bits 2:1 in byte mode)
// - protection query puts the sector address on upper bits; nonzero means protected
// - host refuses sector-unprotect unless the protection mask shows every sector protected and the reset pin is elevated
// - a write happens only with chip and write enable low and output enable high
// - host writes reset when the timeout error bit rises or a bank is identifying
package fcpa_pkg;
	// clock and bus cycle timing
	localparam int CLK_MHZ = 40;
	localparam int T_SETUP_NS = 25;
	localparam int T_WP_NS = 35;
	localparam int T_ACC_NS = 70;
	localparam int T_HV_NS = 1000;
	localparam int T_RP_NS = 500;
	localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
	localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
	localparam int HV_CYC = (T_HV_NS * CLK_MHZ + 999) / 1000;
	localparam int RP_CYC = (T_RP_NS * CLK_MHZ + 999) / 1000;
	localparam int SYNC_CYC = 2;

	// widths
	localparam int ADDR_W = 20;
	localparam int DQ_W = 16;
	localparam int SECTORS = 22;
	localparam int TIMEOUT_BIT = 5;

	// software register indices
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h1;
	localparam logic [3:0] REG_WDATA = 4'h2;
	localparam logic [3:0] REG_RDATA = 4'h3;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_CONFIG = 4'h5;
	localparam logic [3:0] REG_PROT_MASK = 4'h6;

	// field positions
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_ITEM_LSB = 4;
	localparam int ST_BUSY = 0;
	localparam int ST_REFUSED = 1;
	localparam int ST_TIMEOUT = 2;
	localparam int ST_ID_HV = 3;
	localparam int ST_RST_HV = 4;
	localparam int CFG_BYTE = 0;
	localparam int CFG_RST_HV = 1;

	// reset values
	localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
	localparam logic [DQ_W-1:0] DATA_RST = 16'h0000;
	localparam logic [SECTORS-1:0] MASK_RST = 22'h000000;

	// operations started by a CTRL write
	typedef enum logic [2:0] {
		OP_READ,
		OP_WRITE,
		OP_RESET,
		OP_AUTOSEL,
		OP_HV_ID,
		OP_POLL,
		OP_UNPROT
	} fcpa_op_type;
endpackage : fcpa_pkg

// ===== design/fcpa_bus_cycle.sv
// one asynchronous flash bus cycle, read or write, with strobe timing
`timescale 1ns/1ps
module fcpa_bus_cycle (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	// request
	input wire logic i_start,
	input wire logic i_write,
	input wire logic [fcpa_pkg::ADDR_W-1:0] i_addr,
	input wire logic [fcpa_pkg::DQ_W-1:0] i_wdata,
	output logic o_done,
	output logic [fcpa_pkg::DQ_W-1:0] o_rdata,
	// flash pins
	input wire logic [fcpa_pkg::DQ_W-1:0] i_dq,
	output logic o_ce_n,
	output logic o_oe_n,
	output logic o_we_n,
	output logic [fcpa_pkg::ADDR_W-1:0] o_addr,
	output logic [fcpa_pkg::DQ_W-1:0] o_dq,
	output logic o_dq_oe
);
	typedef enum logic [2:0] {C_IDLE, C_SETUP, C_STROBE, C_SYNC, C_HOLD} fcpa_cyc_type;

	fcpa_cyc_type state_q;
	logic write_q;
	logic [7:0] cnt_q;
	logic [fcpa_pkg::DQ_W-1:0] dq_s1_q;
	logic [fcpa_pkg::DQ_W-1:0] dq_s2_q;

	// data pins pass two flops before capture
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			dq_s1_q <= fcpa_pkg::DATA_RST;
			dq_s2_q <= fcpa_pkg::DATA_RST;
		end
		else
		begin
			dq_s1_q <= i_dq;
			dq_s2_q <= dq_s1_q;
		end
	end

	// cycle sequencer; strobes idle high so power-up starts no command
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state_q <= C_IDLE;
			write_q <= 1'b0;
			cnt_q <= 8'h00;
			o_done <= 1'b0;
			o_rdata <= fcpa_pkg::DATA_RST;
			o_ce_n <= 1'b1;
			o_oe_n <= 1'b1;
			o_we_n <= 1'b1;
			o_addr <= fcpa_pkg::ADDR_RST;
			o_dq <= fcpa_pkg::DATA_RST;
			o_dq_oe <= 1'b0;
		end
		else
		begin
			o_done <= 1'b0;
			unique case (state_q)
				C_IDLE:
				begin
					o_ce_n <= 1'b1;
					o_oe_n <= 1'b1;
					o_we_n <= 1'b1;
					o_dq_oe <= 1'b0;
					if (i_start)
					begin
						// address and data settle as chip enable falls, before output or write enable falls
						o_addr <= i_addr;
						o_dq <= i_wdata;
						o_dq_oe <= i_write;
						write_q <= i_write;
						o_ce_n <= 1'b0;
						cnt_q <= 8'(fcpa_pkg::SETUP_CYC);
						state_q <= C_SETUP;
					end
				end
				C_SETUP:
				begin
					if (cnt_q == 8'h01)
					begin
						// write enable only falls with output enable high
						o_we_n <= ~write_q;
						o_oe_n <= write_q;
						cnt_q <= write_q ? 8'(fcpa_pkg::WP_CYC) : 8'(fcpa_pkg::ACC_CYC);
						state_q <= C_STROBE;
					end
					else
						cnt_q <= cnt_q - 8'h01;
				end
				C_STROBE:
				begin
					if (cnt_q == 8'h01)
					begin
						if (write_q)
						begin
							// write enable rises first so data latch here
							o_we_n <= 1'b1;
							state_q <= C_HOLD;
						end
						else
						begin
							cnt_q <= 8'(fcpa_pkg::SYNC_CYC);
							state_q <= C_SYNC;
						end
					end
					else
						cnt_q <= cnt_q - 8'h01;
				end
				C_SYNC:
				begin
					if (cnt_q == 8'h01)
					begin
						o_rdata <= dq_s2_q;
						o_oe_n <= 1'b1;
						state_q <= C_HOLD;
					end
					else
						cnt_q <= cnt_q - 8'h01;
				end
				C_HOLD:
				begin
					o_ce_n <= 1'b1;
					o_done <= 1'b1;
					state_q <= C_IDLE;
				end
			endcase
		end
	end
endmodule : fcpa_bus_cycle

// ===== design/fcpa_host.sv
// host controller driving the flash command, identification and protection pins
`timescale 1ns/1ps
module fcpa_host #(
	parameter logic [fcpa_pkg::ADDR_W-1:0] P_UNLOCK_ADDR1 = 20'h00555,
	parameter logic [fcpa_pkg::ADDR_W-1:0] P_UNLOCK_ADDR2 = 20'h002AA,
	parameter logic [fcpa_pkg::DQ_W-1:0] P_UNLOCK_DATA1 = 16'h00AA,
	parameter logic [fcpa_pkg::DQ_W-1:0] P_UNLOCK_DATA2 = 16'h0055,
	parameter logic [fcpa_pkg::DQ_W-1:0] P_AUTOSEL_CMD = 16'h0090,
	parameter logic [fcpa_pkg::DQ_W-1:0] P_RESET_CMD = 16'h00F0
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	// software register port
	input wire logic [3:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata,
	// flash bus
	input wire logic [fcpa_pkg::DQ_W-1:0] i_dq,
	output logic [fcpa_pkg::DQ_W-1:0] o_dq,
	output logic o_dq_oe,
	output logic [fcpa_pkg::ADDR_W-1:0] o_flash_addr,
	output logic o_ce_n,
	output logic o_oe_n,
	output logic o_we_n,
	output logic o_byte_n,
	output logic o_flash_reset_n,
	// high-voltage switch enables
	output logic o_id_hv_en,
	output logic o_reset_hv_en
);
	typedef enum logic [2:0] {M_RST_PIN, M_IDLE, M_HV_RISE, M_ISSUE, M_WAIT, M_HV_FALL} fcpa_main_type;

	fcpa_main_type state_q;
	fcpa_pkg::fcpa_op_type op_q;
	logic [2:0] step_q;
	logic [7:0] cnt_q;
	logic [1:0] item_q;
	logic [fcpa_pkg::ADDR_W-1:0] addr_q;
	logic [fcpa_pkg::DQ_W-1:0] wdata_q;
	logic [fcpa_pkg::DQ_W-1:0] rdata_q;
	logic [fcpa_pkg::SECTORS-1:0] mask_q;
	logic cfg_byte_q;
	logic cfg_rst_hv_q;
	logic refused_q;
	logic timeout_q;
	logic start_q;
	logic [fcpa_pkg::DQ_W-1:0] cyc_rdata;
	logic cyc_done;
	logic ctrl_wr;
	logic op_legal;
	logic refuse_now;
	logic timeout_now;
	logic [37:0] step_info;
	logic [fcpa_pkg::ADDR_W-1:0] id_addr;

	// identification address: sector and bank on upper bits, bit 6 low, item on bits 1:0 (bits 2:1 in byte mode)
	assign id_addr = {addr_q[fcpa_pkg::ADDR_W-1:8], 8'(item_q) << cfg_byte_q};

	// shift a word address into byte addressing when byte mode is selected
	function automatic logic [fcpa_pkg::ADDR_W-1:0] fcpa_mode_addr(input logic [fcpa_pkg::ADDR_W-1:0] a,
		input logic byte_mode);
		fcpa_mode_addr = byte_mode ? {a[fcpa_pkg::ADDR_W-2:0], 1'b0} : a;
	endfunction : fcpa_mode_addr

	// one step of each operation: {last, write, address, data}
	function automatic logic [37:0] fcpa_step(input fcpa_pkg::fcpa_op_type op, input logic [2:0] step,
		input logic [fcpa_pkg::ADDR_W-1:0] a, input logic [fcpa_pkg::DQ_W-1:0] d,
		input logic [fcpa_pkg::ADDR_W-1:0] ida, input logic byte_mode);
		logic [fcpa_pkg::ADDR_W-1:0] u1;
		logic [fcpa_pkg::ADDR_W-1:0] u2;
		u1 = fcpa_mode_addr(P_UNLOCK_ADDR1, byte_mode);
		u2 = fcpa_mode_addr(P_UNLOCK_ADDR2, byte_mode);
		fcpa_step = {1'b1, 1'b0, a, d};
		unique case (op)
			fcpa_pkg::OP_READ: fcpa_step = {1'b1, 1'b0, a, d};
			fcpa_pkg::OP_WRITE: fcpa_step = {1'b1, 1'b1, a, d};
			fcpa_pkg::OP_UNPROT: fcpa_step = {1'b1, 1'b1, a, d};
			fcpa_pkg::OP_RESET: fcpa_step = {1'b1, 1'b1, a, P_RESET_CMD};
			fcpa_pkg::OP_HV_ID: fcpa_step = {1'b1, 1'b0, ida, d};
			fcpa_pkg::OP_POLL:
				fcpa_step = (step == 3'h0) ? {1'b1, 1'b0, a, d} : {1'b1, 1'b1, a, P_RESET_CMD};
			fcpa_pkg::OP_AUTOSEL:
			begin
				// unlock, unlock, bank plus command, identification read, then reset to leave
				unique case (step)
					3'h0: fcpa_step = {1'b0, 1'b1, u1, P_UNLOCK_DATA1};
					3'h1: fcpa_step = {1'b0, 1'b1, u2, P_UNLOCK_DATA2};
					3'h2: fcpa_step = {1'b0, 1'b1, {a[fcpa_pkg::ADDR_W-1:12], u1[11:0]}, P_AUTOSEL_CMD};
					3'h3: fcpa_step = {1'b0, 1'b0, ida, d};
					default: fcpa_step = {1'b1, 1'b1, a, P_RESET_CMD};
				endcase
			end
		endcase
	endfunction : fcpa_step

	assign step_info = fcpa_step(op_q, step_q, addr_q, wdata_q, id_addr, cfg_byte_q);
	assign ctrl_wr = i_reg_wr && (i_reg_addr == fcpa_pkg::REG_CTRL);
	assign op_legal = i_reg_wdata[fcpa_pkg::CTRL_OP_LSB +: 3] != 3'h7;
	// unprotect only once every sector is confirmed protected and reset pin is elevated
	assign refuse_now = ctrl_wr && ((state_q != M_IDLE) || !op_legal ||
		((fcpa_pkg::fcpa_op_type'(i_reg_wdata[fcpa_pkg::CTRL_OP_LSB +: 3]) == fcpa_pkg::OP_UNPROT) &&
		(!(&mask_q) || !cfg_rst_hv_q)));
	assign timeout_now = (state_q == M_WAIT) && cyc_done && (op_q == fcpa_pkg::OP_POLL) &&
		(step_q == 3'h0) && cyc_rdata[fcpa_pkg::TIMEOUT_BIT];

	// operation sequencer
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state_q <= M_RST_PIN;
			op_q <= fcpa_pkg::OP_READ;
			step_q <= 3'h0;
			cnt_q <= 8'(fcpa_pkg::RP_CYC);
			item_q <= 2'b00;
			start_q <= 1'b0;
			o_flash_reset_n <= 1'b0;
			o_id_hv_en <= 1'b0;
		end
		else
		begin
			start_q <= 1'b0;
			unique case (state_q)
				M_RST_PIN:
				begin
					// pulse the flash reset pin; afterwards it reads array with no command
					if (cnt_q == 8'h01)
					begin
						o_flash_reset_n <= 1'b1;
						state_q <= M_IDLE;
					end
					else
						cnt_q <= cnt_q - 8'h01;
				end
				M_IDLE:
				begin
					if (ctrl_wr && !refuse_now)
					begin
						op_q <= fcpa_pkg::fcpa_op_type'(i_reg_wdata[fcpa_pkg::CTRL_OP_LSB +: 3]);
						item_q <= i_reg_wdata[fcpa_pkg::CTRL_ITEM_LSB +: 2];
						step_q <= 3'h0;
						if (fcpa_pkg::fcpa_op_type'(i_reg_wdata[fcpa_pkg::CTRL_OP_LSB +: 3]) == fcpa_pkg::OP_HV_ID)
						begin
							o_id_hv_en <= 1'b1;
							cnt_q <= 8'(fcpa_pkg::HV_CYC);
							state_q <= M_HV_RISE;
						end
						else
							state_q <= M_ISSUE;
					end
				end
				M_HV_RISE:
				begin
					if (cnt_q == 8'h01)
						state_q <= M_ISSUE;
					else
						cnt_q <= cnt_q - 8'h01;
				end
				M_ISSUE:
				begin
					start_q <= 1'b1;
					state_q <= M_WAIT;
				end
				M_WAIT:
				begin
					if (cyc_done)
					begin
						if (timeout_now || !step_info[37])
						begin
							step_q <= step_q + 3'h1;
							state_q <= M_ISSUE;
						end
						else if (op_q == fcpa_pkg::OP_HV_ID)
						begin
							o_id_hv_en <= 1'b0;
							cnt_q <= 8'(fcpa_pkg::HV_CYC);
							state_q <= M_HV_FALL;
						end
						else
							state_q <= M_IDLE;
					end
				end
				M_HV_FALL:
				begin
					if (cnt_q == 8'h01)
						state_q <= M_IDLE;
					else
						cnt_q <= cnt_q - 8'h01;
				end
			endcase
		end
	end

	// captured read data: identification item, status or array word
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			rdata_q <= fcpa_pkg::DATA_RST;
		else if ((state_q == M_WAIT) && cyc_done && !step_info[36])
			rdata_q <= cfg_byte_q ? {8'h00, cyc_rdata[7:0]} : cyc_rdata;
	end

	// software-written registers
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			addr_q <= fcpa_pkg::ADDR_RST;
			wdata_q <= fcpa_pkg::DATA_RST;
			mask_q <= fcpa_pkg::MASK_RST;
			cfg_byte_q <= 1'b0;
			cfg_rst_hv_q <= 1'b0;
		end
		else if (i_reg_wr)
		begin
			if (i_reg_addr == fcpa_pkg::REG_ADDR && state_q == M_IDLE)
				addr_q <= i_reg_wdata[fcpa_pkg::ADDR_W-1:0];
			if (i_reg_addr == fcpa_pkg::REG_WDATA && state_q == M_IDLE)
				wdata_q <= i_reg_wdata[fcpa_pkg::DQ_W-1:0];
			if (i_reg_addr == fcpa_pkg::REG_PROT_MASK)
				mask_q <= i_reg_wdata[fcpa_pkg::SECTORS-1:0];
			if (i_reg_addr == fcpa_pkg::REG_CONFIG && state_q == M_IDLE)
			begin
				cfg_byte_q <= i_reg_wdata[fcpa_pkg::CFG_BYTE];
				cfg_rst_hv_q <= i_reg_wdata[fcpa_pkg::CFG_RST_HV];
			end
		end
	end

	// sticky flags, cleared by writing one; a new event wins over the clear
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			refused_q <= 1'b0;
			timeout_q <= 1'b0;
		end
		else
		begin
			if (refuse_now)
				refused_q <= 1'b1;
			else if (i_reg_wr && i_reg_addr == fcpa_pkg::REG_STATUS && i_reg_wdata[fcpa_pkg::ST_REFUSED])
				refused_q <= 1'b0;
			if (timeout_now)
				timeout_q <= 1'b1;
			else if (i_reg_wr && i_reg_addr == fcpa_pkg::REG_STATUS && i_reg_wdata[fcpa_pkg::ST_TIMEOUT])
				timeout_q <= 1'b0;
		end
	end

	// read data one cycle after the read strobe; unmapped reads return zero
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_reg_rdata <= 32'h00000000;
		else if (i_reg_rd)
		begin
			unique case (i_reg_addr)
				fcpa_pkg::REG_CTRL: o_reg_rdata <= {26'h0000000, item_q, 1'b0, op_q};
				fcpa_pkg::REG_ADDR: o_reg_rdata <= {12'h000, addr_q};
				fcpa_pkg::REG_WDATA: o_reg_rdata <= {16'h0000, wdata_q};
				fcpa_pkg::REG_RDATA: o_reg_rdata <= {16'h0000, rdata_q};
				fcpa_pkg::REG_STATUS: o_reg_rdata <= {27'h0000000, cfg_rst_hv_q, o_id_hv_en, timeout_q,
					refused_q, state_q != M_IDLE};
				fcpa_pkg::REG_CONFIG: o_reg_rdata <= {30'h00000000, cfg_rst_hv_q, cfg_byte_q};
				fcpa_pkg::REG_PROT_MASK: o_reg_rdata <= {10'h000, mask_q};
				default: o_reg_rdata <= 32'h00000000;
			endcase
		end
		else
			o_reg_rdata <= 32'h00000000;
	end

	assign o_byte_n = ~cfg_byte_q;
	assign o_reset_hv_en = cfg_rst_hv_q;

	// bus cycle engine shared by every operation
	fcpa_bus_cycle u_cycle (
		.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_start(start_q),
		.i_write(step_info[36]),
		.i_addr(step_info[35:16]),
		.i_wdata(step_info[15:0]),
		.o_done(cyc_done),
		.o_rdata(cyc_rdata),
		.i_dq(i_dq),
		.o_ce_n(o_ce_n),
		.o_oe_n(o_oe_n),
		.o_we_n(o_we_n),
		.o_addr(o_flash_addr),
		.o_dq(o_dq),
		.o_dq_oe(o_dq_oe)
	);
endmodule : fcpa_host

// ===== test/fcpa_host_assertions.sv
// checker bound to the flash host controller ports
`timescale 1ns/1ps
module fcpa_host_assertions (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	// flash pins
	input wire logic [15:0] o_dq,
	input wire logic o_dq_oe,
	input wire logic [19:0] o_flash_addr,
	input wire logic o_ce_n,
	input wire logic o_oe_n,
	input wire logic o_we_n,
	input wire logic o_flash_reset_n,
	input wire logic o_id_hv_en
);
	logic [5:0] cnt_q;
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_reset_n);
	// cycles since reset release, saturating
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			cnt_q <= 6'h00;
		else if (cnt_q != 6'h3F)
			cnt_q <= cnt_q + 6'h01;
	end
	// strobe and data relations on the flash bus
	a_no_fight: assert property (!(!o_oe_n && !o_we_n))
		else $error("output and write enable low together");
	a_write_frame: assert property (!o_we_n |-> !o_ce_n && o_oe_n && o_dq_oe)
		else $error("write strobe outside a driven chip select");
	a_read_free: assert property (!o_oe_n |-> !o_ce_n && !o_dq_oe)
		else $error("read strobe while host drives data");
	a_we_width: assert property ($fell(o_we_n) |=> !o_we_n ##1 o_we_n)
		else $error("write pulse not two cycles");
	a_addr_held: assert property (!o_ce_n && $past(!o_ce_n) |-> $stable(o_flash_addr))
		else $error("address moved inside a cycle");
	a_data_held: assert property (!o_we_n || $rose(o_we_n) |-> $stable(o_dq))
		else $error("write data moved before strobe rise");
	a_ce_gap: assert property ($rose(o_ce_n) |=> o_ce_n)
		else $error("chip select gap too short");
	a_rst_low: assert property (cnt_q < 6'h12 |-> !o_flash_reset_n && o_ce_n)
		else $error("flash reset released too early");
	a_rst_high: assert property (cnt_q > 6'h16 |-> o_flash_reset_n)
		else $error("flash reset held too long");
	a_hv_read_only: assert property (o_id_hv_en |-> o_we_n)
		else $error("write while identify voltage applied");
	a_hv_settle: assert property ($rose(o_id_hv_en) |-> o_oe_n [*8])
		else $error("read before identify voltage settled");
	// main scenarios
	c_write: cover property ($fell(o_we_n));
	c_hv_read: cover property ($fell(o_oe_n) && o_id_hv_en);
	c_plain_read: cover property ($fell(o_oe_n) && !o_id_hv_en);
endmodule : fcpa_host_assertions

bind fcpa_host fcpa_host_assertions u_fcpa_host_assertions (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
	.o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_flash_addr(o_flash_addr), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n),
	.o_we_n(o_we_n), .o_flash_reset_n(o_flash_reset_n), .o_id_hv_en(o_id_hv_en));

// ===== test/fcpa_flash_model.sv
// behavioural flash device answering the host's bus cycles
`timescale 1ns/1ps
module fcpa_flash_model #(
	parameter logic [7:0] P_MAKER = 8'h3C, // arbitrary value
	parameter logic [15:0] P_DEVICE = 16'h5D96, // arbitrary value
	parameter logic [15:0] P_PROT_ON = 16'h0081
) (
	// strobes, mode pins and address
	input wire logic i_ce_n,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	input wire logic i_byte_n,
	input wire logic i_rst_n,
	input wire logic [19:0] i_addr,
	// data lines
	input wire logic [15:0] i_dq,
	output logic [15:0] o_dq,
	// elevated-voltage detects
	input wire logic i_id_hv,
	input wire logic i_reset_hv
);
	logic [15:0] prot_q = 16'h0000;
	logic [1:0] step_q = 2'h0;
	logic ident_q = 1'b0;
	logic [15:0] last_q = 16'h0000;
	logic [15:0] rd_val;
	logic [19:0] lat_a;
	logic [18:0] la;
	realtime t_fall;
	int writes_seen = 0;
	int resets_seen = 0;
	int blocked_seen = 0;
	logic susp_q = 1'b0;
	wire wr_act = !i_ce_n && !i_we_n && i_oe_n;
	wire [18:0] wa = i_byte_n ? i_addr[18:0] : i_addr[19:1];
	wire prot_eff = prot_q[wa[18:15]] && !i_reset_hv;
	wire [15:0] dev = i_byte_n ? P_DEVICE : {8'h00, P_DEVICE[7:0]};
	// address on the later falling strobe
	always @(posedge wr_act)
	begin
		lat_a = i_addr;
		t_fall = $realtime;
	end
	// command decode on the earlier rising strobe; short pulses dropped
	always @(negedge wr_act)
	begin
		la = i_byte_n ? lat_a[18:0] : lat_a[19:1];
		if ($realtime - t_fall >= 5.0 && i_rst_n)
		begin
			writes_seen++;
			// writes that land in a protected sector without the reset pin elevated are counted as refused
			if (prot_eff)
				blocked_seen++;
			if (i_dq[7:0] == 8'hF0)
			begin
				// susp_q is kept, so a suspended bank goes back to suspend read
				ident_q = 1'b0;
				step_q = 2'h0;
				resets_seen++;
			end
			else if (i_dq[7:0] == 8'hB0)
			begin
				susp_q = 1'b1;
				step_q = 2'h0;
			end
			else if (step_q == 2'h0 && la[10:0] == 11'h555 && i_dq[7:0] == 8'hAA)
				step_q = 2'h1;
			else if (step_q == 2'h1 && la[10:0] == 11'h2AA && i_dq[7:0] == 8'h55)
				step_q = 2'h2;
			else if (step_q == 2'h2 && la[10:0] == 11'h555 && i_dq[7:0] == 8'h90)
			begin
				ident_q = 1'b1;
				step_q = 2'h0;
			end
			else
				step_q = 2'h0;
		end
	end
	// hardware reset pin returns to array read
	always @(negedge i_rst_n)
	begin
		ident_q = 1'b0;
		step_q = 2'h0;
	end
	// read value by mode
	always @*
	begin
		if (i_id_hv && !wa[6])
			rd_val = wa[1:0] == 2'h0 ? {8'h00, P_MAKER} : wa[1:0] == 2'h1 ? dev : prot_eff ? P_PROT_ON : 16'h0000;
		else if (ident_q)
			rd_val = wa[7:0] == 8'h00 ? {8'h00, P_MAKER} : wa[7:0] == 8'h01 ? dev : prot_eff ? P_PROT_ON : 16'h0000;
		else
			rd_val = {wa[7:0], ~wa[7:0]};
	end
	// released lines show the inverse of the last value
	always @(posedge i_oe_n)
		last_q <= rd_val;
	assign o_dq = (!i_ce_n && !i_oe_n) ? rd_val : ~last_q;
endmodule : fcpa_flash_model

// ===== test/testbench.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module testbench;
	localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
	localparam logic [15:0] DEVICE = 16'h5D96; // arbitrary value
	localparam logic [15:0] PROT_ON = 16'h0081;
	logic i_ref_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic [3:0] i_reg_addr = 4'h0;
	logic [31:0] i_reg_wdata = 32'h0;
	logic i_reg_wr = 1'b0;
	logic i_reg_rd = 1'b0;
	logic [31:0] o_reg_rdata;
	logic [31:0] rd;
	logic [15:0] o_dq;
	logic [15:0] fl_dq;
	logic [19:0] o_flash_addr;
	logic o_dq_oe, o_ce_n, o_oe_n, o_we_n, o_byte_n, o_flash_reset_n, o_id_hv_en, o_reset_hv_en;
	logic [15:0] id_exp [3] = '{{8'h00, MAKER}, DEVICE, PROT_ON};
	int err_count = 0;
	int checks_done = 0;
	int cycles = 0;
	int n;
	int m;
	wire [15:0] bus_dq = o_dq_oe ? o_dq : fl_dq;
	// clock source
	always #12.5 i_ref_clk = ~i_ref_clk;
	fcpa_host u_fcpa_host (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr),
		.i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
		.i_dq(bus_dq), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_flash_addr(o_flash_addr), .o_ce_n(o_ce_n),
		.o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_byte_n(o_byte_n), .o_flash_reset_n(o_flash_reset_n),
		.o_id_hv_en(o_id_hv_en), .o_reset_hv_en(o_reset_hv_en));
	fcpa_flash_model #(.P_MAKER(MAKER), .P_DEVICE(DEVICE), .P_PROT_ON(PROT_ON)) u_fcpa_flash_model (
		.i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_byte_n(o_byte_n), .i_rst_n(o_flash_reset_n),
		.i_addr(o_flash_addr), .i_dq(bus_dq), .o_dq(fl_dq), .i_id_hv(o_id_hv_en), .i_reset_hv(o_reset_hv_en));
	// compare and count
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// one register write cycle
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_ref_clk);
		i_reg_wr <= 1'b0;
		// let the strobed register settle before any caller looks at a pin
		#1;
	endtask : reg_wr
	// one register read cycle, data in the following cycle
	task automatic reg_rd(input logic [3:0] a);
		@(posedge i_ref_clk);
		i_reg_rd <= 1'b1;
		i_reg_addr <= a;
		@(posedge i_ref_clk);
		i_reg_rd <= 1'b0;
		#1 rd = o_reg_rdata;
	endtask : reg_rd
	// start an operation, wait for idle, fetch captured data
	task automatic run_op(input fcpa_pkg::fcpa_op_type op, input logic [1:0] item, input logic [19:0] a);
		reg_wr(fcpa_pkg::REG_ADDR, {12'h000, a});
		reg_wr(fcpa_pkg::REG_CTRL, {26'h0000000, item, 1'b0, op});
		repeat (2) @(posedge i_ref_clk);
		for (int i = 0; i < 300; i++)
		begin
			reg_rd(fcpa_pkg::REG_STATUS);
			if (rd[0] === 1'b0)
				break;
		end
		reg_rd(fcpa_pkg::REG_RDATA);
	endtask : run_op
	// verdict and end of run
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	// hang guard
	always @(posedge i_ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			complete_run();
		end
	end
	// test sequence
	initial
	begin
		repeat (8) @(posedge i_ref_clk);
		i_reset_n <= 1'b1;
		repeat (25) @(posedge i_ref_clk);
		check("reset pin", 32'(o_flash_reset_n), 32'h1);
		reg_rd(fcpa_pkg::REG_STATUS);
		check("status", rd, 32'h0);
		reg_rd(4'hF);
		check("unmapped", rd, 32'h0);
		reg_rd(fcpa_pkg::REG_PROT_MASK);
		check("mask", rd, 32'h0);
		$display("test reset done");
		run_op(fcpa_pkg::OP_READ, 2'h0, 20'h00040);
		check("array", rd, 32'h40BF);
		$display("test read done");
		u_fcpa_flash_model.prot_q[3] = 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			run_op(fcpa_pkg::OP_AUTOSEL, i[1:0], 20'h18000);
			check("autoselect", rd, {16'h0000, id_exp[i]});
			check("ident left", 32'(u_fcpa_flash_model.ident_q), 32'h0);
			run_op(fcpa_pkg::OP_HV_ID, i[1:0], 20'h18000);
			check("hv id", rd, {16'h0000, id_exp[i]});
		end
		run_op(fcpa_pkg::OP_HV_ID, 2'h2, 20'h00000);
		check("unprotected", rd, 32'h0);
		check("hv off", 32'(o_id_hv_en), 32'h0);
		reg_wr(fcpa_pkg::REG_CONFIG, 32'h1);
		check("byte pin", 32'(o_byte_n), 32'h0);
		run_op(fcpa_pkg::OP_HV_ID, 2'h1, 20'h18000);
		check("byte device", rd, {24'h000000, DEVICE[7:0]});
		reg_wr(fcpa_pkg::REG_CONFIG, 32'h0);
		$display("test identify done");
		n = u_fcpa_flash_model.resets_seen;
		run_op(fcpa_pkg::OP_POLL, 2'h0, 20'h00020);
		reg_rd(fcpa_pkg::REG_STATUS);
		check("no timeout", rd, 32'h0);
		run_op(fcpa_pkg::OP_POLL, 2'h0, 20'h00000);
		reg_rd(fcpa_pkg::REG_STATUS);
		check("timeout", rd, 32'h4);
		check("reset sent", 32'(u_fcpa_flash_model.resets_seen), 32'(n + 1));
		reg_wr(fcpa_pkg::REG_STATUS, 32'h6);
		$display("test poll done");
		m = u_fcpa_flash_model.blocked_seen;
		run_op(fcpa_pkg::OP_WRITE, 2'h0, 20'h18000);
		check("write blocked", 32'(u_fcpa_flash_model.blocked_seen), 32'(m + 1));
		n = u_fcpa_flash_model.writes_seen;
		reg_wr(fcpa_pkg::REG_CTRL, 32'h7);
		reg_rd(fcpa_pkg::REG_STATUS);
		check("bad op", rd, 32'h2);
		reg_wr(fcpa_pkg::REG_STATUS, 32'h2);
		run_op(fcpa_pkg::OP_UNPROT, 2'h0, 20'h18000);
		reg_rd(fcpa_pkg::REG_STATUS);
		check("unprot refused", rd, 32'h2);
		check("no write", 32'(u_fcpa_flash_model.writes_seen), 32'(n));
		reg_wr(fcpa_pkg::REG_STATUS, 32'h2);
		reg_wr(fcpa_pkg::REG_PROT_MASK, 32'h003FFFFF);
		reg_wr(fcpa_pkg::REG_CONFIG, 32'h2);
		check("reset hv", 32'(o_reset_hv_en), 32'h1);
		run_op(fcpa_pkg::OP_UNPROT, 2'h0, 20'h18000);
		reg_rd(fcpa_pkg::REG_STATUS);
		check("unprot ok", rd, 32'h10);
		check("one write", 32'(u_fcpa_flash_model.writes_seen), 32'(n + 1));
		check("write allowed", 32'(u_fcpa_flash_model.blocked_seen), 32'(m + 1));
		reg_wr(fcpa_pkg::REG_CONFIG, 32'h0);
		$display("test protect done");
		reg_wr(fcpa_pkg::REG_WDATA, 32'hB0);
		run_op(fcpa_pkg::OP_WRITE, 2'h0, 20'h00000);
		check("suspended", 32'(u_fcpa_flash_model.susp_q), 32'h1);
		run_op(fcpa_pkg::OP_READ, 2'h0, 20'h00040);
		check("suspend read", rd, 32'h40BF);
		n = u_fcpa_flash_model.resets_seen;
		reg_wr(fcpa_pkg::REG_WDATA, 32'hAA);
		run_op(fcpa_pkg::OP_WRITE, 2'h0, 20'h00555);
		check("unlock step", 32'(u_fcpa_flash_model.step_q), 32'h1);
		run_op(fcpa_pkg::OP_RESET, 2'h0, 20'h12345);
		check("abort", 32'(u_fcpa_flash_model.step_q), 32'h0);
		check("reset count", 32'(u_fcpa_flash_model.resets_seen), 32'(n + 1));
		check("suspend kept", 32'(u_fcpa_flash_model.susp_q), 32'h1);
		run_op(fcpa_pkg::OP_WRITE, 2'h0, 20'h00555);
		reg_wr(fcpa_pkg::REG_WDATA, 32'h77);
		run_op(fcpa_pkg::OP_WRITE, 2'h0, 20'h002AA);
		check("bad cycle", 32'(u_fcpa_flash_model.step_q), 32'h0);
		$display("test sequence done");
		complete_run();
	end
endmodule : testbench
